// *** ipl_core_model.sv ***
// Purpose: Core side that latches prioritised requests
// Assumes: Same clock as the register block
// Notes: No masking by level; every valid request is taken
`timescale 1ns/1ps
module ipl_core_model (
    // Core side
    input wire logic clk,
    input wire logic [ipl_pkg::NSRC-1:0] req_valid,
    output logic [ipl_pkg::NSRC-1:0] pending
);
    always_ff @(posedge clk) pending <= req_valid;
endmodule

// *** ipl_map.sv ***
// Purpose: Maps a 2-bit priority code to a core level and enable
// Assumes: Combinational, used once per source
// Notes: Debug sources sit one level higher than peripheral sources
`timescale 1ns/1ps
module ipl_map (
    // Field
    input wire logic [1:0] code,
    input wire logic debug_kind,
    // Result
    output logic enabled,
    output logic [1:0] level
);
    assign enabled = (code != ipl_pkg::CODE_OFF);
    // Debug codes 01..11 give 1..3, others give 0..2
    assign level = debug_kind ? code : code - 2'h1;
endmodule

// *** ipl_pkg.sv ***
// Purpose: Shared constants for the interrupt priority level register block
// Assumes: Avalon-MM slave with 32-bit data, word aligned registers
// Notes: Printed offsets are register indexes; byte address is four times the index
package ipl_pkg;
    // Register indexes and address width
    localparam logic [3:0] IDX_DEBUG = 4'h1;
    localparam logic [3:0] IDX_SYSTEM = 4'h2;
    localparam logic [3:0] IDX_PORT_CAN = 4'h3;
    localparam logic [3:0] IDX_STATUS = 4'h4;
    localparam logic [3:0] IDX_LOWPOWER = 4'h5;
    localparam int ADDR_W = 6;
    // Write masks: implemented field bits, reserved bits stay zero
    localparam logic [15:0] MASK_DEBUG = 16'h003F;
    localparam logic [15:0] MASK_SYSTEM = 16'hFFCF;
    localparam logic [15:0] MASK_PORT_CAN = 16'hFFFC;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    // Debug register fields
    localparam int POS_DBG_RX = 4;
    localparam int POS_DBG_TX = 2;
    localparam int POS_DBG_TRACE = 0;
    // System register fields
    localparam int POS_FL_BUF_EMPTY = 14;
    localparam int POS_FL_CMD_DONE = 12;
    localparam int POS_FL_FAULT = 10;
    localparam int POS_PLL_LOST = 8;
    localparam int POS_LOW_VOLT = 6;
    localparam int POS_EXT_B = 2;
    localparam int POS_EXT_A = 0;
    // Port and CAN register fields
    localparam int POS_PORT_D = 14;
    localparam int POS_PORT_E = 12;
    localparam int POS_PORT_F = 10;
    localparam int POS_CAN_MAILBOX = 8;
    localparam int POS_CAN_WAKE = 6;
    localparam int POS_CAN_FAULT = 4;
    localparam int POS_CAN_BUS_OFF = 2;
    // Source count and encodings
    localparam int NSRC = 17;
    localparam int NDBG = 3;
    localparam logic [1:0] CODE_OFF = 2'h0;
    // Low power control bit position
    localparam int POS_LP_ENTER = 0;
endpackage

// *** ipl_regs.sv ***
// Purpose: Priority level registers for debug, system, port and CAN sources
// Assumes: Single clock, synchronous active high reset, Avalon-MM with waitrequest
// Notes: Each read or write completes one cycle after it is presented
//
// Behaviour
// [RL1] Reserved bits read as zero and ignore writes.
// [RL2] Debug codes: 00 off, 01 level 1, 10 level 2, 11 level 3.
// [RL3] Peripheral codes: 00 off, 01 level 0, 10 level 1, 11 level 2.
// [RL4] Reset leaves every register zero and every source disabled.
// [RL5] Debug register: rx full 5-4, tx empty 3-2, trace 1-0.
// [RL6] System register: flash buffers empty 15-14, cmd done 13-12, fault 11-10.
// [RL7] System register: PLL lost lock 9-8, low voltage 7-6.
// [RL8] System register: 5-4 reserved, line B 3-2, line A 1-0.
// [RL9] Port register: port D 15-14, port E 13-12, port F 11-10.
// [RL10] Port register: CAN mailbox 9-8, wake 7-6, fault 5-4, bus off 3-2.
// [RL11] In low power, only sources enabled before entry may wake the core.
// [RL12] Forward levels to arbitration; never request for a disabled source.
`timescale 1ns/1ps
module ipl_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [ipl_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Raw source requests, same clock
    input wire logic [ipl_pkg::NSRC-1:0] src_req,
    // Prioritised requests toward the core
    output logic [ipl_pkg::NSRC-1:0] req_valid,
    output logic [2*ipl_pkg::NSRC-1:0] req_level,
    output logic wake_req
);
    logic [15:0] debug_source_priority;
    logic [15:0] system_source_priority;
    logic [15:0] port_and_can_priority;
    logic [15:0] lp_ctrl;
    logic [ipl_pkg::NSRC-1:0] lp_enabled;
    logic done;

    // Decode
    wire [3:0] idx = avs_address[ipl_pkg::ADDR_W-1:2];
    wire aligned = (avs_address[1:0] == 2'h0);
    wire sel_dbg = aligned && (idx == ipl_pkg::IDX_DEBUG);
    wire sel_sys = aligned && (idx == ipl_pkg::IDX_SYSTEM);
    wire sel_pc = aligned && (idx == ipl_pkg::IDX_PORT_CAN);
    wire sel_st = aligned && (idx == ipl_pkg::IDX_STATUS);
    wire sel_lp = aligned && (idx == ipl_pkg::IDX_LOWPOWER);
    wire mapped = sel_dbg | sel_sys | sel_pc | sel_st | sel_lp;
    wire active = (avs_read | avs_write) & ~done;
    wire do_wr = avs_write & ~done & clk_en;
    wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Merge a write through byte enables and the implemented-bit mask
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [15:0] be, input logic [15:0] impl);
        merge = ((old & ~be) | (wd & be)) & impl;
    endfunction

    wire [15:0] next_dbg = merge(debug_source_priority, avs_writedata[15:0], be_mask,
                                 ipl_pkg::MASK_DEBUG); // RL1
    wire [15:0] next_sys = merge(system_source_priority, avs_writedata[15:0], be_mask,
                                 ipl_pkg::MASK_SYSTEM); // RL1
    wire [15:0] next_pc = merge(port_and_can_priority, avs_writedata[15:0], be_mask,
                                ipl_pkg::MASK_PORT_CAN); // RL1
    wire [15:0] next_lp = merge(lp_ctrl, avs_writedata[15:0], be_mask, 16'h0001);

    // Field extraction in source order
    wire [2*ipl_pkg::NSRC-1:0] codes = {
        port_and_can_priority[ipl_pkg::POS_CAN_BUS_OFF +: 2], // RL10
        port_and_can_priority[ipl_pkg::POS_CAN_FAULT +: 2], // RL10
        port_and_can_priority[ipl_pkg::POS_CAN_WAKE +: 2], // RL10
        port_and_can_priority[ipl_pkg::POS_CAN_MAILBOX +: 2], // RL10
        port_and_can_priority[ipl_pkg::POS_PORT_F +: 2], // RL9
        port_and_can_priority[ipl_pkg::POS_PORT_E +: 2], // RL9
        port_and_can_priority[ipl_pkg::POS_PORT_D +: 2], // RL9
        system_source_priority[ipl_pkg::POS_EXT_A +: 2], // RL8
        system_source_priority[ipl_pkg::POS_EXT_B +: 2], // RL8
        system_source_priority[ipl_pkg::POS_LOW_VOLT +: 2], // RL7
        system_source_priority[ipl_pkg::POS_PLL_LOST +: 2], // RL7
        system_source_priority[ipl_pkg::POS_FL_FAULT +: 2], // RL6
        system_source_priority[ipl_pkg::POS_FL_CMD_DONE +: 2], // RL6
        system_source_priority[ipl_pkg::POS_FL_BUF_EMPTY +: 2], // RL6
        debug_source_priority[ipl_pkg::POS_DBG_TRACE +: 2], // RL5
        debug_source_priority[ipl_pkg::POS_DBG_TX +: 2], // RL5
        debug_source_priority[ipl_pkg::POS_DBG_RX +: 2] // RL5
    };

    logic [ipl_pkg::NSRC-1:0] en;
    logic [2*ipl_pkg::NSRC-1:0] lvl;
    genvar g;
    generate
        for (g = 0; g < ipl_pkg::NSRC; g++) begin : g_src
            ipl_map u_map (
                .code(codes[2*g +: 2]),
                .debug_kind(g < ipl_pkg::NDBG), // RL2 RL3
                .enabled(en[g]),
                .level(lvl[2*g +: 2])
            );
        end
    endgenerate

    // Disabled sources never raise a request
    wire [ipl_pkg::NSRC-1:0] next_valid = src_req & en; // RL12
    wire in_lp = lp_ctrl[ipl_pkg::POS_LP_ENTER];
    // Wake uses the enables captured at entry, so late changes cannot wake
    wire next_wake = in_lp & |(src_req & lp_enabled); // RL11

    // Status shows the live requests currently passed on for sources 0 to 15
    wire [15:0] status_rd = req_valid[15:0];
    wire [15:0] rd_val = sel_dbg ? debug_source_priority :
                         sel_sys ? system_source_priority :
                         sel_pc ? port_and_can_priority :
                         sel_lp ? lp_ctrl :
                         sel_st ? status_rd : 16'h0000;

    // Bus answer one cycle after the request; waitrequest low at that edge
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else if (clk_en) begin
            done <= active;
            // Registered inverse of active so the bus output comes from a flop
            avs_waitrequest <= ~active;
            if (active) begin
                avs_readdata <= {16'h0000, rd_val}; // RL1
                avs_response <= mapped ? 2'h0 : 2'h3;
            end
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            debug_source_priority <= ipl_pkg::RESET_VAL; // RL4
            system_source_priority <= ipl_pkg::RESET_VAL; // RL4
            port_and_can_priority <= ipl_pkg::RESET_VAL; // RL4
            lp_ctrl <= ipl_pkg::RESET_VAL;
        end else if (do_wr) begin
            if (sel_dbg) debug_source_priority <= next_dbg;
            if (sel_sys) system_source_priority <= next_sys;
            if (sel_pc) port_and_can_priority <= next_pc;
            if (sel_lp) lp_ctrl <= next_lp;
        end
    end

    // Outputs and low power snapshot
    always_ff @(posedge clk) begin
        if (rst) begin
            req_valid <= '0;
            req_level <= '0;
            wake_req <= 1'b0;
            lp_enabled <= '0;
        end else if (clk_en) begin
            req_valid <= next_valid; // RL12
            req_level <= lvl; // RL12
            wake_req <= next_wake; // RL11
            if (!in_lp) lp_enabled <= en; // RL11
        end
    end
endmodule

// *** ipl_regs_chk.sv ***
// Purpose: Output checks for the priority register block
// Assumes: clk_en held high
// Notes: Bus data checked only where a read completes
`timescale 1ns/1ps
module ipl_regs_chk (
    // Clock and bus
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    // Sources and core side
    input wire logic [16:0] src_req,
    input wire logic [16:0] req_valid,
    input wire logic [33:0] req_level,
    input wire logic wake_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic rd = avs_read && !avs_waitrequest;
    property zero_at(a, m); rd && avs_address == a |-> (avs_readdata & m) == 32'h0; endproperty
    dbg_rsv_a: assert property (zero_at(6'h04, 32'hFFFFFFC0)) else $error("rsv");
    sys_rsv_a: assert property (zero_at(6'h08, 32'hFFFF0030)) else $error("rsv");
    port_rsv_a: assert property (zero_at(6'h0C, 32'hFFFF0003)) else $error("rsv");
    unmapped_read_a: assert property (zero_at(6'h20, 32'hFFFFFFFF)) else $error("map");
    dbg_lvl_a: assert property (req_valid[0] |-> req_level[1:0] != 2'h0) else $error("lvl");
    per_lvl_a: assert property (req_valid[3] |-> req_level[7:6] != 2'h3) else $error("lvl");
    off_req_a: assert property ((req_valid & ~$past(src_req)) == 17'h0) else $error("off");
    wake_cause_a: assert property (wake_req |-> $past(src_req) != 17'h0) else $error("wk");
    cover property (req_valid == 17'h0FFFF);
    cover property (wake_req);
    cover property (rd && avs_address == 6'h20);
endmodule
bind ipl_regs ipl_regs_chk ipl_regs_chk_i (.*);

// *** irq_priority_level_regs_test.sv ***
// Purpose: Register, level and wake tests
// Assumes: clk_en and byteenable held high
// Notes: Expected levels packed by hand from field codes
`timescale 1ns/1ps
module irq_priority_level_regs_test;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, wake_req;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [1:0] avs_response;
    logic [16:0] src_req = 17'h0, req_valid, pending;
    logic [33:0] req_level;
    logic [15:0] tbl [6] = '{16'hFFF9, 16'hE7B9, 16'h6DB3, 16'h0039, 16'hE789, 16'h6DB0};
    int fails = 0, num_checks = 0;
    always #5 clk = ~clk;
    ipl_regs ipl_regs_i (.*, .clk_en(1'b1), .avs_byteenable(4'hF));
    ipl_core_model ipl_core_model_i (.*);
    task automatic chk(input logic [33:0] got, logic [33:0] exp);
        num_checks++;
        fails += int'(got !== exp);
        if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, int a, logic [31:0] d, logic [33:0] e);
        logic [33:0] got;
        avs_address <= 6'(a);
        avs_writedata <= d;
        {avs_read, avs_write} <= {!wr, wr};
        // Look mid-cycle so the value seen is the one the next edge samples
        @(negedge clk);
        while (avs_waitrequest !== 1'b0) @(negedge clk);
        got = {avs_response, avs_readdata};
        @(posedge clk);
        {avs_read, avs_write} <= 2'b00;
        if (!wr) chk(got, e);
        @(posedge clk);
    endtask
    task automatic src(input logic [16:0] v, logic [16:0] e, logic w);
        src_req <= v;
        repeat (2) @(posedge clk);
        chk({wake_req, req_valid}, {w, e});
        @(posedge clk);
        chk(pending, e);
    endtask
    task automatic results(input int late);
        fails += late;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial #100000 results(1);
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 4 * i + 4, 32'h0, 34'h0);
            bus(1'b1, 4 * i + 4, {16'hFFFF, tbl[i]}, 34'h0);
            bus(1'b0, 4 * i + 4, 32'h0, {18'h0, tbl[i + 3]});
        end
        src(17'h1FFFF, 17'h0FFFF, 1'b0);
        chk(req_level[31:0], 32'h9241619B);
        bus(1'b0, 16, 32'h0, 34'h0FFFF);
        bus(1'b0, 32, 32'h0, 34'h300000000);
        bus(1'b1, 20, 32'h1, 34'h0);
        src(17'h00001, 17'h00001, 1'b1);
        bus(1'b1, 12, 32'h6DB4, 34'h0);
        src(17'h10000, 17'h10000, 1'b0);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        src(17'h1FFFF, 17'h00000, 1'b0);
        results(0);
    end
endmodule
